// ### hdl/nrr_gain_shaper.sv
// Gain trajectory of one residual suppressor, shaped by the two ramp rates.
`timescale 1ns/10ps
module nrr_gain_shaper #(
   parameter int unsigned RATE_W = 16
) (
   // Clock, reset and enable.
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // Control.
   input  wire logic              enable_i,
   input  wire logic              tick_i,
   input  wire logic              suppress_i,
   // Ramp rates.
   input  wire logic [RATE_W-1:0] engage_rate_i,
   input  wire logic [RATE_W-1:0] release_rate_i,
   // Gain.
   output logic      [RATE_W-1:0] gain_o
);
   logic [2*RATE_W-1:0] prod;   // Gain times the active rate.
   logic [RATE_W:0]     scaled; // Product back in unity format.
   logic [RATE_W:0]     raised; // Release step plus one lsb.
   logic [RATE_W-1:0]   gain_d; // Next gain.

   // Each step multiplies the gain by the active rate in unity format.
   always_comb begin
      prod   = gain_o * (suppress_i ? engage_rate_i : release_rate_i);
      scaled = prod[nrr_pkg::FRAC_BITS +: RATE_W+1];
      raised = scaled + (RATE_W+1)'(1);
      if (!enable_i) begin
         gain_d = nrr_pkg::GAIN_UNITY;
      end else if (suppress_i) begin
         // A smaller rate shrinks the gain more per step.
         gain_d = (scaled >= {1'b0, nrr_pkg::GAIN_UNITY}) ? nrr_pkg::GAIN_UNITY
                                                          : scaled[RATE_W-1:0];
      end else begin
         // A larger rate grows it more per step; the added lsb lets it leave zero.
         gain_d = (raised >= {1'b0, nrr_pkg::GAIN_UNITY}) ? nrr_pkg::GAIN_UNITY
                                                          : raised[RATE_W-1:0];
      end
   end

   // The gain moves once per sample tick and starts with no attenuation.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gain_o <= nrr_pkg::GAIN_UNITY;
      end else if (ce_i && tick_i) begin
         gain_o <= gain_d;
      end
   end
endmodule : nrr_gain_shaper

// ### hdl/nrr_pkg.sv
// Constants, register map and reset values of the ramp rate register bank.
//==============================================================================
//==============================================================================
package nrr_pkg;

   //===========================================================================
   // Sizes.
   //===========================================================================
   localparam int unsigned NUM_CANCELLERS = 2;  // Cancellers A and B.
   localparam int unsigned SLOTS_PER_CANC = 4;  // Byte registers per canceller.
   localparam int unsigned NUM_SLOTS      = 8;  // Byte registers in total.
   localparam int unsigned RATE_W         = 16; // Width of one ramp rate.
   localparam int unsigned BYTE_W         = 8;  // Width of one register.
   localparam int unsigned IDX_W          = 6;  // Width of a register index.
   localparam int unsigned ADR_LSB        = 2;  // Byte address is index times four.
   localparam int unsigned ADR_W          = 8;  // Width of the bus byte address.
   localparam int unsigned DAT_W          = 32; // Width of the bus data.
   localparam int unsigned SEL_W          = 4;  // Width of the bus byte select.

   //===========================================================================
   // Register indices of the documented byte registers.
   //===========================================================================
   localparam logic [5:0] CANCELLER_A_RELEASE_SLOPE_LOW_IDX  = 6'h1a;
   localparam logic [5:0] CANCELLER_A_RELEASE_SLOPE_HIGH_IDX = 6'h1b;
   localparam logic [5:0] CANCELLER_A_ENGAGE_SLOPE_LOW_IDX   = 6'h1c;
   localparam logic [5:0] CANCELLER_A_ENGAGE_SLOPE_HIGH_IDX  = 6'h1d;
   localparam logic [5:0] CANCELLER_B_RELEASE_SLOPE_LOW_IDX  = 6'h3a;
   localparam logic [5:0] CANCELLER_B_RELEASE_SLOPE_HIGH_IDX = 6'h3b;
   localparam logic [5:0] CANCELLER_B_ENGAGE_SLOPE_LOW_IDX   = 6'h3c;
   localparam logic [5:0] CANCELLER_B_ENGAGE_SLOPE_HIGH_IDX  = 6'h3d;

   //===========================================================================
   // Position of each byte inside a canceller's group of four slots.
   //===========================================================================
   localparam int unsigned SLOT_ENG_LO = 0; // Engage rate bits 7:0.
   localparam int unsigned SLOT_ENG_HI = 1; // Engage rate bits 15:8.
   localparam int unsigned SLOT_REL_LO = 2; // Release rate bits 7:0.
   localparam int unsigned SLOT_REL_HI = 3; // Release rate bits 15:8.

   // Index and reset value of every slot, canceller A first.
   localparam logic [5:0] SLOT_IDX [0:7] = '{
      CANCELLER_A_RELEASE_SLOPE_LOW_IDX, CANCELLER_A_RELEASE_SLOPE_HIGH_IDX,
      CANCELLER_A_ENGAGE_SLOPE_LOW_IDX,  CANCELLER_A_ENGAGE_SLOPE_HIGH_IDX,
      CANCELLER_B_RELEASE_SLOPE_LOW_IDX, CANCELLER_B_RELEASE_SLOPE_HIGH_IDX,
      CANCELLER_B_ENGAGE_SLOPE_LOW_IDX,  CANCELLER_B_ENGAGE_SLOPE_HIGH_IDX};
   localparam logic [7:0] SLOT_RST [0:7] = '{
      8'h00, 8'h3e, 8'h00, 8'h41, 8'h00, 8'h3e, 8'h00, 8'h41};

   //===========================================================================
   // Extra registers: gain readback, control and status.
   //===========================================================================
   localparam logic [5:0] GAIN_LO_IDX [0:1] = '{6'h04, 6'h24}; // Gain bits 7:0.
   localparam logic [5:0] GAIN_HI_IDX [0:1] = '{6'h05, 6'h25}; // Gain bits 15:8.
   localparam logic [5:0] CTRL_IDX          = 6'h3e;           // Shaping enables.
   localparam logic [5:0] STATUS_IDX        = 6'h3f;           // Rate range flags.
   localparam logic [7:0] CTRL_RST          = 8'h03;           // Both cancellers on.
   localparam int unsigned STATUS_ENG_LSB   = 0; // Bit per canceller: engage rate bad.
   localparam int unsigned STATUS_REL_LSB   = 2; // Bit per canceller: release rate bad.

   //===========================================================================
   // Fixed point format of rates and gain.
   //===========================================================================
   localparam int unsigned FRAC_BITS  = 14;       // Unity is one shifted by this.
   localparam logic [15:0] GAIN_UNITY = 16'h4000; // No attenuation.

endpackage : nrr_pkg

// ### hdl/nrr_ramp_rate_bank.sv
// Ramp rate register bank of the residual suppressors of cancellers A and B.
`timescale 1ns/10ps
module nrr_ramp_rate_bank (
   // Clock, reset and enable.
   input  wire logic                                    clk_i,
   input  wire logic                                    rst_i,
   input  wire logic                                    ce_i,
   // Wishbone slave.
   input  wire logic                                    wb_cyc_i,
   input  wire logic                                    wb_stb_i,
   input  wire logic                                    wb_we_i,
   input  wire logic [nrr_pkg::ADR_W-1:0]               wb_adr_i,
   input  wire logic [nrr_pkg::SEL_W-1:0]               wb_sel_i,
   input  wire logic [nrr_pkg::DAT_W-1:0]               wb_dat_i,
   output logic      [nrr_pkg::DAT_W-1:0]               wb_dat_o,
   output logic                                         wb_ack_o,
   // Suppressor control from the canceller datapath.
   input  wire logic [nrr_pkg::NUM_CANCELLERS-1:0]      suppress_req_i,
   input  wire logic                                    sample_tick_i,
   // Ramp constants and gain toward the suppressors.
   output logic [nrr_pkg::NUM_CANCELLERS-1:0][nrr_pkg::RATE_W-1:0] engage_ramp_rate_o,
   output logic [nrr_pkg::NUM_CANCELLERS-1:0][nrr_pkg::RATE_W-1:0] release_ramp_rate_o,
   output logic [nrr_pkg::NUM_CANCELLERS-1:0][nrr_pkg::RATE_W-1:0] suppressor_gain_readback_o
);

   //===========================================================================
   // Declarations.
   //===========================================================================
   // Register access from the bus front end.
   nrr_reg_if regs ();

   // Current value of every byte register, slot order as in the package.
   logic [nrr_pkg::BYTE_W-1:0] slot_val [0:nrr_pkg::NUM_SLOTS-1];

   // Shaping enable per canceller, written by software.
   logic [nrr_pkg::BYTE_W-1:0] ctrl_q;

   // Rate range flags, refreshed every enabled cycle from the programmed rates.
   logic [nrr_pkg::BYTE_W-1:0] status_q;

   // Status value computed from the rates, before its flop.
   logic [nrr_pkg::BYTE_W-1:0] status_d;

   // Rates assembled straight from the byte registers.
   logic [nrr_pkg::NUM_CANCELLERS-1:0][nrr_pkg::RATE_W-1:0] engage_raw;
   logic [nrr_pkg::NUM_CANCELLERS-1:0][nrr_pkg::RATE_W-1:0] release_raw;

   // Gain of each suppressor, straight from the shaper flops.
   logic [nrr_pkg::NUM_CANCELLERS-1:0][nrr_pkg::RATE_W-1:0] gain;

   // High gain byte frozen when the low byte is read.
   logic [nrr_pkg::BYTE_W-1:0] gain_hi_shadow_q [0:nrr_pkg::NUM_CANCELLERS-1];

   // Read byte presented to the front end.
   logic [nrr_pkg::BYTE_W-1:0] rdata;

   //===========================================================================
   // Bus front end.
   //===========================================================================
   // The front end answers every addressed cycle and turns it into strobes.
   nrr_wb_front u_front (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .regs     (regs.front)
   );

   //===========================================================================
   // Byte registers of the ramp rates.
   //===========================================================================
   // One read-write byte per slot, each with its own index and reset value.
   // A write touches only the addressed byte; its partner keeps its value.
   for (genvar s = 0; s < nrr_pkg::NUM_SLOTS; s++) begin : g_slot
      logic [nrr_pkg::BYTE_W-1:0] val_q; // Stored byte.

      // Load the byte when software writes its index.
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            val_q <= nrr_pkg::SLOT_RST[s];
         end else if (regs.wr_stb && regs.idx == nrr_pkg::SLOT_IDX[s]) begin
            val_q <= regs.wdata;
         end
      end

      assign slot_val[s] = val_q;
   end

   //===========================================================================
   // Control register.
   //===========================================================================
   // Bit c enables gain shaping for canceller c; clear holds its gain at unity.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= nrr_pkg::CTRL_RST;
      end else if (regs.wr_stb && regs.idx == nrr_pkg::CTRL_IDX) begin
         ctrl_q <= regs.wdata;
      end
   end

   //===========================================================================
   // Rate assembly.
   //===========================================================================
   // Each rate is its high byte above its low byte.
   for (genvar c = 0; c < nrr_pkg::NUM_CANCELLERS; c++) begin : g_rate
      localparam int unsigned BASE = c * nrr_pkg::SLOTS_PER_CANC; // First slot.

      assign engage_raw[c]  = {slot_val[BASE + nrr_pkg::SLOT_ENG_HI],
                               slot_val[BASE + nrr_pkg::SLOT_ENG_LO]};
      assign release_raw[c] = {slot_val[BASE + nrr_pkg::SLOT_REL_HI],
                               slot_val[BASE + nrr_pkg::SLOT_REL_LO]};
   end

   // The constants seen by the suppressors come from flops, so they change
   // only the cycle after a byte write and are steady in between.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int c = 0; c < nrr_pkg::NUM_CANCELLERS; c++) begin
            engage_ramp_rate_o[c]  <= {nrr_pkg::SLOT_RST[c*4+1], nrr_pkg::SLOT_RST[c*4]};
            release_ramp_rate_o[c] <= {nrr_pkg::SLOT_RST[c*4+3], nrr_pkg::SLOT_RST[c*4+2]};
         end
      end else if (ce_i) begin
         engage_ramp_rate_o  <= engage_raw;
         release_ramp_rate_o <= release_raw;
      end
   end

   //===========================================================================
   // Rate range status.
   //===========================================================================
   // Software must keep the engage rate below unity and the release rate above
   // it; the block still runs with other values but flags them here so that a
   // driver fault is visible. The shaper saturates so no value can overflow.
   always_comb begin
      status_d = '0;
      for (int c = 0; c < nrr_pkg::NUM_CANCELLERS; c++) begin
         status_d[nrr_pkg::STATUS_ENG_LSB + c] =
            (engage_ramp_rate_o[c] >= nrr_pkg::GAIN_UNITY);
         status_d[nrr_pkg::STATUS_REL_LSB + c] =
            (release_ramp_rate_o[c] <= nrr_pkg::GAIN_UNITY);
      end
   end

   // The flags follow the rates; writes to this register are ignored.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_q <= '0;
      end else if (ce_i) begin
         status_q <= status_d;
      end
   end

   //===========================================================================
   // Suppressor gain shapers.
   //===========================================================================
   // One shaper per canceller; each steps on the shared sample tick.
   for (genvar c = 0; c < nrr_pkg::NUM_CANCELLERS; c++) begin : g_shaper
      nrr_gain_shaper #(
         .RATE_W (nrr_pkg::RATE_W)
      ) u_shaper (
         .clk_i          (clk_i),
         .rst_i          (rst_i),
         .ce_i           (ce_i),
         .enable_i       (ctrl_q[c]),
         .tick_i         (sample_tick_i),
         .suppress_i     (suppress_req_i[c]),
         .engage_rate_i  (engage_ramp_rate_o[c]),
         .release_rate_i (release_ramp_rate_o[c]),
         .gain_o         (gain[c])
      );
   end

   // The gain leaves the block as it stands in the shaper flops.
   assign suppressor_gain_readback_o = gain;

   //===========================================================================
   // Gain readback coherence.
   //===========================================================================
   // Reading the low gain byte freezes the high byte, so that a low-then-high
   // pair of reads returns one coherent sixteen-bit value even while the gain
   // keeps moving between the two bus cycles.
   for (genvar c = 0; c < nrr_pkg::NUM_CANCELLERS; c++) begin : g_shadow
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            gain_hi_shadow_q[c] <= nrr_pkg::GAIN_UNITY[15:8];
         end else if (regs.rd_stb && regs.idx == nrr_pkg::GAIN_LO_IDX[c]) begin
            gain_hi_shadow_q[c] <= gain[c][15:8];
         end
      end
   end

   //===========================================================================
   // Read multiplexer.
   //===========================================================================
   // Unmapped indices read as zero; the front end still answers them.
   always_comb begin
      rdata = '0;
      // Ramp rate bytes.
      for (int s = 0; s < nrr_pkg::NUM_SLOTS; s++) begin
         if (regs.idx == nrr_pkg::SLOT_IDX[s]) begin
            rdata = slot_val[s];
         end
      end
      // Gain bytes, high byte from the shadow.
      for (int c = 0; c < nrr_pkg::NUM_CANCELLERS; c++) begin
         if (regs.idx == nrr_pkg::GAIN_LO_IDX[c]) begin
            rdata = gain[c][7:0];
         end
         if (regs.idx == nrr_pkg::GAIN_HI_IDX[c]) begin
            rdata = gain_hi_shadow_q[c];
         end
      end
      // Control and status.
      if (regs.idx == nrr_pkg::CTRL_IDX) begin
         rdata = ctrl_q;
      end
      if (regs.idx == nrr_pkg::STATUS_IDX) begin
         rdata = status_q;
      end
   end

   assign regs.rdata = rdata;

endmodule : nrr_ramp_rate_bank

// ### hdl/nrr_reg_if.sv
// Register access carrier between the bus front end and the register bank.
`timescale 1ns/10ps
interface nrr_reg_if;
   logic                         wr_stb; // One-cycle write of wdata at idx.
   logic                         rd_stb; // One-cycle read capture at idx.
   logic [nrr_pkg::IDX_W-1:0]    idx;    // Register index.
   logic [nrr_pkg::BYTE_W-1:0]   wdata;  // Write byte.
   logic [nrr_pkg::BYTE_W-1:0]   rdata;  // Read byte at idx.

   modport front (output wr_stb, rd_stb, idx, wdata, input rdata);
   modport bank  (input wr_stb, rd_stb, idx, wdata, output rdata);
endinterface : nrr_reg_if

// ### hdl/nrr_wb_front.sv
// Classic Wishbone slave front end of the ramp rate register bank.
`timescale 1ns/10ps
module nrr_wb_front (
   // Clock, reset and enable.
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         ce_i,
   // Wishbone slave.
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [nrr_pkg::ADR_W-1:0]    wb_adr_i,
   input  wire logic [nrr_pkg::SEL_W-1:0]    wb_sel_i,
   input  wire logic [nrr_pkg::DAT_W-1:0]    wb_dat_i,
   output logic      [nrr_pkg::DAT_W-1:0]    wb_dat_o,
   output logic                              wb_ack_o,
   // Register access.
   nrr_reg_if.front                          regs
);
   logic req; // A cycle is addressed to this slave.
   logic ack_q; // Answer flag, high for exactly one enabled cycle.

   assign req          = wb_cyc_i & wb_stb_i;
   assign regs.idx     = wb_adr_i[nrr_pkg::ADR_LSB +: nrr_pkg::IDX_W];
   assign regs.wdata   = wb_dat_i[nrr_pkg::BYTE_W-1:0];
   // The write lands on the edge at which the master samples the answer.
   assign regs.wr_stb  = ce_i & req & wb_we_i & ack_q & wb_sel_i[0];
   // Read data is captured on the edge that raises the answer.
   assign regs.rd_stb  = ce_i & req & ~wb_we_i & ~ack_q;
   assign wb_ack_o     = ack_q;

   // Answer every addressed cycle, mapped or not, one cycle after it is seen.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else if (ce_i) begin
         ack_q <= req & ~ack_q;
      end
   end

   // Read data sits in the low byte; the bits above read as zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (regs.rd_stb) begin
         wb_dat_o <= {{(nrr_pkg::DAT_W-nrr_pkg::BYTE_W){1'b0}}, regs.rdata};
      end
   end
endmodule : nrr_wb_front

// ### testbench/nrr_ramp_rate_bank_props.sv
// Concurrent checks on the ports of the ramp rate register bank.
`timescale 1ns/10ps
module nrr_ramp_rate_bank_props (
   // Clock, reset and enable.
   input wire logic                                   clk_i,
   input wire logic                                   rst_i,
   input wire logic                                   ce_i,
   // Wishbone slave.
   input wire logic                                   wb_cyc_i,
   input wire logic                                   wb_stb_i,
   input wire logic                                   wb_we_i,
   input wire logic [nrr_pkg::ADR_W-1:0]              wb_adr_i,
   input wire logic [nrr_pkg::DAT_W-1:0]              wb_dat_o,
   input wire logic                                   wb_ack_o,
   // Suppressor side.
   input wire logic [1:0]                             suppress_req_i,
   input wire logic                                   sample_tick_i,
   input wire logic [1:0][15:0]                       engage_ramp_rate_o,
   input wire logic [1:0][15:0]                       release_ramp_rate_o,
   input wire logic [1:0][15:0]                       suppressor_gain_readback_o
);
   // ==========================================================================
   // Setup
   // ==========================================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // A request that the slave may take on this edge.
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence

   // ==========================================================================
   // Assertions
   // ==========================================================================
   ack_one_cycle_a: assert property (req_s |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single cycle after request");
   ack_has_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("bus ack without request");
   rd_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   reset_values_a: assert property ($fell(rst_i) |->
      engage_ramp_rate_o == {2{16'h3e00}} && release_ramp_rate_o == {2{16'h4100}}
      && suppressor_gain_readback_o == {2{16'h4000}})
      else $error("wrong values after reset");
   rate_hold_a: assert property (!$stable(engage_ramp_rate_o) |->
      $past(wb_ack_o && wb_we_i, 2) || $past(rst_i) || $past(rst_i, 2))
      else $error("engage rate changed without a write");
   read_map_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h1b
      |-> wb_dat_o[7:0] == engage_ramp_rate_o[0][15:8])
      else $error("engage high byte readback differs from rate");
   gain_step_a: assert property (!$stable(suppressor_gain_readback_o) |->
      $past(sample_tick_i && ce_i) || $past(rst_i) || $past(rst_i, 2))
      else $error("gain changed without a tick");
   gain_ceiling_a: assert property (suppressor_gain_readback_o[0] <= 16'h4000 &&
      suppressor_gain_readback_o[1] <= 16'h4000)
      else $error("gain above unity");
   unity_stays_a: assert property (sample_tick_i && ce_i && !suppress_req_i[0] &&
      suppressor_gain_readback_o[0] == 16'h4000 |=> suppressor_gain_readback_o[0] == 16'h4000)
      else $error("released gain left unity");
endmodule : nrr_ramp_rate_bank_props

bind nrr_ramp_rate_bank nrr_ramp_rate_bank_props props_u (.clk_i, .rst_i, .ce_i,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .suppress_req_i,
   .sample_tick_i, .engage_ramp_rate_o, .release_ramp_rate_o, .suppressor_gain_readback_o);

// ### testbench/nrr_ramp_rate_bank_tb_top.sv
// Self-checking testbench of the ramp rate register bank.
`timescale 1ns/10ps
module nrr_ramp_rate_bank_tb_top;
   // ==========================================================================
   // Stimulus and observed signals
   // ==========================================================================
   logic             clk_i = 1'b0;
   logic             rst_i = 1'b1;
   logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0, ce = 1'b1;
   logic [7:0]       adr = 8'h00;
   logic [3:0]       sel = 4'h0;
   logic [31:0]      dat = 32'h0, dat_o, q;
   logic             ack;
   logic [1:0]       sup = 2'h0;
   logic [1:0][15:0] eng, rel, gain;
   int               err_count = 0, n_checks = 0;

   always #5 clk_i = ~clk_i;

   nrr_ramp_rate_bank dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .suppress_req_i(sup), .sample_tick_i(tick),
      .engage_ramp_rate_o(eng), .release_ramp_rate_o(rel), .suppressor_gain_readback_o(gain));

   // ==========================================================================
   // Tasks
   // ==========================================================================
   // Ends the run with the counts and the verdict.
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done

   // Compares a seen value with the expected one.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One classic cycle; the request is held until ack is sampled high.
   task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      input logic [3:0] s);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= {idx, 2'b00};
      sel <= s;
      dat <= {24'h0, d};
      // Wait as long as the slave needs; only the watchdog ends a hang.
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus

   // Read a register and compare the whole data word.
   task automatic rdc(input logic [5:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00, 4'hf);
      chk(q, {24'h0, e});
   endtask : rdc

   // One sample tick with the given suppress requests, then let it settle.
   task automatic step(input logic [1:0] s);
      @(posedge clk_i);
      sup  <= s;
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      @(posedge clk_i);
   endtask : step

   // ==========================================================================
   // Tests
   // ==========================================================================
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // Reset values, then writes that must be ignored.
      for (int i = 0; i < 8; i++) rdc(nrr_pkg::SLOT_IDX[i], nrr_pkg::SLOT_RST[i]);
      chk(eng, 32'h3e00_3e00);
      chk(rel, 32'h4100_4100);
      chk(gain, 32'h4000_4000);
      bus(1'b1, 6'h04, 8'hff, 4'hf);
      rdc(6'h04, 8'h00);
      rdc(6'h05, 8'h40);
      bus(1'b1, 6'h10, 8'h5a, 4'hf);
      rdc(6'h10, 8'h00);
      bus(1'b1, 6'h1a, 8'h77, 4'h0);
      rdc(6'h1a, 8'h00);
      $display("reset and refusal test done");
      // Every slot written and read back; bytes combine into the rates.
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, nrr_pkg::SLOT_IDX[i], 8'(8'h11 * (i + 1)), 4'h1);
         rdc(nrr_pkg::SLOT_IDX[i], 8'(8'h11 * (i + 1)));
         if (i == 0) chk(eng[0], {16'h0, 16'h3e11});
      end
      chk(eng, 32'h6655_2211);
      chk(rel, 32'h8877_4433);
      rdc(6'h3f, 8'h02);
      $display("write and readback test done");
      // Canceller A engages with the smaller rate and releases with the larger.
      bus(1'b1, 6'h1a, 8'h00, 4'h1);
      bus(1'b1, 6'h1b, 8'h20, 4'h1);
      bus(1'b1, 6'h3a, 8'h00, 4'h1);
      bus(1'b1, 6'h3b, 8'h30, 4'h1);
      bus(1'b1, 6'h1c, 8'h00, 4'h1);
      bus(1'b1, 6'h1d, 8'h80, 4'h1);
      bus(1'b1, 6'h3c, 8'h00, 4'h1);
      bus(1'b1, 6'h3d, 8'h41, 4'h1);
      step(2'b11);
      chk(gain, 32'h3000_2000);
      step(2'b11);
      chk(gain, 32'h2400_1000);
      step(2'b00);
      chk(gain, 32'h2491_2001);
      rdc(6'h04, 8'h01);
      rdc(6'h05, 8'h20);
      step(2'b00);
      chk(gain, 32'h2524_4000);
      // A tick while the clock enable is low must leave both gains alone.
      ce <= 1'b0;
      step(2'b11);
      chk(gain, 32'h2524_4000);
      ce <= 1'b1;
      // Released gain at unity stays there; canceller B keeps rising.
      step(2'b00);
      chk(gain, 32'h25b9_4000);
      // Shaping off for canceller A holds its gain at unity while B engages.
      bus(1'b1, 6'h3e, 8'h02, 4'h1);
      rdc(6'h3e, 8'h02);
      step(2'b11);
      chk(gain, 32'h1c4a_4000);
      $display("gain shaping test done");
      test_done();
   end

   // Cuts a hung run short after far more time than the tests need.
   initial begin
      #200000;
      err_count++;
      test_done();
   end
endmodule : nrr_ramp_rate_bank_tb_top
